// *** verilog/sar_adc_sequencer_defs.vh ***
// constants for the successive-approximation converter sequencer
// assumes a 20 MHz peripheral clock and byte-wide register stores
`ifndef SAR_ADC_SEQUENCER_DEFS_VH
`define SAR_ADC_SEQUENCER_DEFS_VH
// ==========================================================
// register addresses
`define ADDR_MODE_REG 32'hFFFF_F3C0
`define ADDR_CHANNEL_SELECT 32'hFFFF_F3C2
`define ADDR_RESULT_REG 32'hFFFF_F3C4
// ==========================================================
// reset values
`define MODE_RESET 8'h00
`define CHANNEL_RESET 8'h00
`define RESULT_RESET 10'h000
// ==========================================================
// mode and channel register fields
`define MODE_ENABLE_BIT 7
`define MODE_HW_START_BIT 6
`define MODE_TIME_HI 5
`define MODE_TIME_LO 3
`define MODE_EDGE_HI 2
`define MODE_EDGE_LO 1
`define MODE_POWER_BIT 0
`define CHANNEL_CODE_MASK 8'h0F
// ==========================================================
// edge codes
`define EDGE_NONE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_RISE 2'h2
`define EDGE_BOTH 2'h3
// ==========================================================
// conversion lengths in clocks, one per timing code
`define CONV_LEN_0 10'h120
`define CONV_LEN_1 10'h0D8
`define CONV_LEN_2 10'h0A8
`define CONV_LEN_3 10'h078
`define CONV_LEN_4 10'h060
`define CONV_LEN_5 10'h048
`define CONV_LEN_6 10'h03C
`define CONV_LEN_7 10'h030
// sampling plus ten trial steps share the length evenly
`define CONV_SLOTS 10'h00B
`define SAR_BITS 10
`endif

// *** verilog/sar_adc_sequencer.v ***
// sar_adc_sequencer: register file, trigger detection and bit-by-bit approximation
// assumes an external comparator, tap selector and sample-hold on the analog side
`include "sar_adc_sequencer_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer
#(
  parameter ADDR_W = 32
)
(
  // clock and reset
  input wire CLK_I,
  input wire RESET_N_I,
  // register access
  input wire [ADDR_W-1:0] ADDR_I,
  input wire WR_I,
  input wire [7:0] WDATA_I,
  input wire [7:0] BIT_MASK_I,
  input wire RD_I,
  output reg [15:0] RDATA_O,
  // chip power state
  input wire LOW_POWER_STOP_I,
  // trigger pin
  input wire EXTERNAL_TRIGGER_IN_I,
  // analog front end
  input wire COMPARATOR_HIGH_I,
  output reg [3:0] CHANNEL_O,
  output reg SAMPLE_O,
  output reg [9:0] TAP_CODE_O,
  output reg COMPARATOR_ON_O,
  // interrupt
  output reg CONVERSION_DONE_IRQ_O
);
  // ==========================================================
  // states
  localparam ST_IDLE = 3'd0;
  localparam ST_WAIT_TRIG = 3'd1;
  localparam ST_STAB = 3'd2;
  localparam ST_SAMPLE = 3'd3;
  localparam ST_TRIAL = 3'd4;
  localparam ST_STORE = 3'd5;

  reg [7:0] mode_q;
  reg [7:0] channel_q;
  reg [9:0] result_q;
  reg [9:0] approx_q;
  reg [2:0] state_q;
  reg [9:0] cnt_q;
  reg [3:0] bit_q;
  reg [9:0] pending_q;
  reg pend_valid_q;
  reg comp_s1_q;
  reg comp_s2_q;
  reg trig_s1_q;
  reg trig_s2_q;
  reg trig_prev_q;
  reg [9:0] conv_len;
  reg [9:0] slot_len;
  reg trig_edge;
  reg [7:0] mode_wr;
  reg [7:0] chan_wr;

  wire wr_mode = WR_I && (ADDR_I == `ADDR_MODE_REG);
  wire wr_chan = WR_I && (ADDR_I == `ADDR_CHANNEL_SELECT);
  wire rd_result = RD_I && (ADDR_I == `ADDR_RESULT_REG);
  // a store to either control register restarts the sequencer
  wire any_wr = wr_mode || wr_chan;
  wire enable = mode_q[`MODE_ENABLE_BIT];
  wire hw_start = mode_q[`MODE_HW_START_BIT];
  wire busy = (state_q == ST_STAB) || (state_q == ST_SAMPLE) || (state_q == ST_TRIAL) || (state_q == ST_STORE);

  // ==========================================================
  // register stores with per-bit mask for single-bit operations
  always @*
  begin
    mode_wr = (mode_q & ~BIT_MASK_I) | (WDATA_I & BIT_MASK_I);
    chan_wr = ((channel_q & ~BIT_MASK_I) | (WDATA_I & BIT_MASK_I)) & `CHANNEL_CODE_MASK;
  end

  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      mode_q <= `MODE_RESET;
      channel_q <= `CHANNEL_RESET;
    end
    else
    begin
      if (wr_mode)
        mode_q <= mode_wr;
      if (wr_chan)
        channel_q <= chan_wr;
    end
  end

  // ==========================================================
  // trigger synchroniser and edge selection
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= EXTERNAL_TRIGGER_IN_I;
      trig_s2_q <= trig_s1_q;
      trig_prev_q <= trig_s2_q;
    end
  end

  always @*
  begin
    case (mode_q[`MODE_EDGE_HI:`MODE_EDGE_LO])
      `EDGE_FALL: trig_edge = trig_prev_q && !trig_s2_q;
      `EDGE_RISE: trig_edge = !trig_prev_q && trig_s2_q;
      `EDGE_BOTH: trig_edge = trig_prev_q ^ trig_s2_q;
      default: trig_edge = 1'b0;
    endcase
  end

  // ==========================================================
  // comparator synchroniser; slots of four clocks or more absorb its lag
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end
    else
    begin
      comp_s1_q <= COMPARATOR_HIGH_I;
      comp_s2_q <= comp_s1_q;
    end
  end

  // ==========================================================
  // conversion length lookup
  always @*
  begin
    case (mode_q[`MODE_TIME_HI:`MODE_TIME_LO])
      3'd0: conv_len = `CONV_LEN_0;
      3'd1: conv_len = `CONV_LEN_1;
      3'd2: conv_len = `CONV_LEN_2;
      3'd3: conv_len = `CONV_LEN_3;
      3'd4: conv_len = `CONV_LEN_4;
      3'd5: conv_len = `CONV_LEN_5;
      3'd6: conv_len = `CONV_LEN_6;
      default: conv_len = `CONV_LEN_7;
    endcase
    // integer division; lengths that do not divide by eleven lose the remainder
    slot_len = conv_len / `CONV_SLOTS;
  end

  // ==========================================================
  // sequencer
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 10'h000;
      bit_q <= 4'h0;
      approx_q <= 10'h000;
      pending_q <= 10'h000;
      pend_valid_q <= 1'b0;
      result_q <= `RESULT_RESET;
      CONVERSION_DONE_IRQ_O <= 1'b0;
    end
    else
    begin
      CONVERSION_DONE_IRQ_O <= 1'b0;
      // the finished code waits one cycle: a read goes first, a store discards it
      if (pend_valid_q)
      begin
        if (any_wr)
          pend_valid_q <= 1'b0;
        else if (!rd_result)
        begin
          pend_valid_q <= 1'b0;
          result_q <= pending_q;
          CONVERSION_DONE_IRQ_O <= 1'b1;
        end
      end
      if (LOW_POWER_STOP_I)
      begin
        state_q <= ST_IDLE;
      end
      else if (any_wr)
      begin
        approx_q <= 10'h000;
        if (wr_mode && !mode_wr[`MODE_ENABLE_BIT])
          state_q <= ST_IDLE;
        else if (wr_mode ? mode_wr[`MODE_HW_START_BIT] : hw_start)
          state_q <= enable || wr_mode ? ST_WAIT_TRIG : ST_IDLE;
        else if (wr_mode || enable)
        begin
          // a mode store brings its own comparator-power choice with it
          if (wr_mode ? mode_wr[`MODE_POWER_BIT] : mode_q[`MODE_POWER_BIT])
            state_q <= ST_STAB;
          else
            state_q <= ST_SAMPLE;
          cnt_q <= 10'h000;
        end
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (enable)
              state_q <= hw_start ? ST_WAIT_TRIG : (mode_q[`MODE_POWER_BIT] ? ST_STAB : ST_SAMPLE);
            cnt_q <= 10'h000;
          end
          ST_WAIT_TRIG:
          begin
            cnt_q <= 10'h000;
            // edges in any other state are dropped, never queued
            if (trig_edge)
              state_q <= mode_q[`MODE_POWER_BIT] ? ST_STAB : ST_SAMPLE;
          end
          ST_STAB:
          begin
            // comparator-off start adds half the length for stabilization
            if (cnt_q >= (conv_len >> 1) - 10'h001)
            begin
              cnt_q <= 10'h000;
              state_q <= ST_SAMPLE;
            end
            else
              cnt_q <= cnt_q + 10'h001;
          end
          ST_SAMPLE:
          begin
            if (cnt_q >= slot_len - 10'h001)
            begin
              cnt_q <= 10'h000;
              bit_q <= 4'd9;
              approx_q <= 10'h200;
              state_q <= ST_TRIAL;
            end
            else
              cnt_q <= cnt_q + 10'h001;
          end
          ST_TRIAL:
          begin
            if (cnt_q >= slot_len - 10'h001)
            begin
              cnt_q <= 10'h000;
              // the decision reads the synchronised comparator at the slot's last clock
              if (!comp_s2_q)
                approx_q[bit_q] <= 1'b0;
              if (bit_q != 4'd0)
              begin
                approx_q[bit_q - 4'd1] <= 1'b1;
                bit_q <= bit_q - 4'd1;
              end
              else
                state_q <= ST_STORE;
            end
            else
              cnt_q <= cnt_q + 10'h001;
          end
          ST_STORE:
          begin
            // hand the code to the commit step; trigger edges here are ignored
            pending_q <= approx_q;
            pend_valid_q <= 1'b1;
            state_q <= hw_start ? ST_WAIT_TRIG : (mode_q[`MODE_POWER_BIT] ? ST_STAB : ST_SAMPLE);
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // read data and analog side outputs
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      RDATA_O <= 16'h0000;
      CHANNEL_O <= 4'h0;
      SAMPLE_O <= 1'b0;
      TAP_CODE_O <= 10'h000;
      COMPARATOR_ON_O <= 1'b0;
    end
    else
    begin
      if (RD_I)
      begin
        if (ADDR_I == `ADDR_MODE_REG)
          RDATA_O <= {8'h00, mode_q};
        else if (ADDR_I == `ADDR_CHANNEL_SELECT)
          RDATA_O <= {8'h00, channel_q};
        else if (rd_result)
          RDATA_O <= {6'h00, result_q};
        else
          RDATA_O <= 16'h0000;
      end
      CHANNEL_O <= channel_q[3:0];
      SAMPLE_O <= (state_q == ST_SAMPLE);
      TAP_CODE_O <= approx_q;
      COMPARATOR_ON_O <= busy && !(state_q == ST_STAB);
    end
  end
endmodule
`default_nettype wire

// *** tb/sar_adc_sequencer_checker.sv ***
// port checker for the converter sequencer, bound into the design
// assumes the shared defines header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_sequencer_defs.vh"
module sar_adc_sequencer_checker
#(
  parameter ADDR_W = 32
)
(
  // clock, reset and register side
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic WR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic [7:0] BIT_MASK_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic LOW_POWER_STOP_I,
  // converter side
  input wire logic SAMPLE_O,
  input wire logic [9:0] TAP_CODE_O,
  input wire logic COMPARATOR_ON_O,
  input wire logic CONVERSION_DONE_IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ==========================================================
  // sequences
  // no store and no power-down lately, so a falling sample flag means the hold began
  sequence calm_s;
    (!WR_I && !LOW_POWER_STOP_I)[*3];
  endsequence
  sequence stop_wr_s;
    WR_I && ADDR_I == `ADDR_MODE_REG && BIT_MASK_I[7] && !WDATA_I[7];
  endsequence
  chk_msb_trial_first: assert property (calm_s ##1 $fell(SAMPLE_O) |-> ##[0:2] TAP_CODE_O == 10'h200)
    else $error("first trial code is not the top bit");
  chk_irq_single: assert property (CONVERSION_DONE_IRQ_O |=> !CONVERSION_DONE_IRQ_O [*8])
    else $error("done pulse repeated too soon");
  chk_irq_after_compare: assert property (CONVERSION_DONE_IRQ_O |-> $past(COMPARATOR_ON_O) || $past(COMPARATOR_ON_O, 2))
    else $error("done pulse without a preceding conversion");
  chk_stop_no_result: assert property (stop_wr_s |=> ##1 (!CONVERSION_DONE_IRQ_O && !SAMPLE_O && !COMPARATOR_ON_O) [*8])
    else $error("conversion went on after disable");
  chk_halt_low_power: assert property (LOW_POWER_STOP_I [*3] |-> !CONVERSION_DONE_IRQ_O)
    else $error("conversion finished in low-power state");
  chk_unmapped_zero: assert property (RD_I && ADDR_I != `ADDR_MODE_REG && ADDR_I != `ADDR_CHANNEL_SELECT
    && ADDR_I != `ADDR_RESULT_REG |=> RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  chk_channel_upper: assert property (RD_I && ADDR_I == `ADDR_CHANNEL_SELECT |=> RDATA_O[15:4] == 12'h000)
    else $error("channel upper bits set");
  chk_result_width: assert property (RD_I && ADDR_I == `ADDR_RESULT_REG |=> RDATA_O[15:10] == 6'h00)
    else $error("result wider than ten bits");
endmodule
bind sar_adc_sequencer sar_adc_sequencer_checker #(.ADDR_W(ADDR_W)) u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .ADDR_I(ADDR_I), .WR_I(WR_I), .WDATA_I(WDATA_I), .BIT_MASK_I(BIT_MASK_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .LOW_POWER_STOP_I(LOW_POWER_STOP_I), .SAMPLE_O(SAMPLE_O), .TAP_CODE_O(TAP_CODE_O),
  .COMPARATOR_ON_O(COMPARATOR_ON_O), .CONVERSION_DONE_IRQ_O(CONVERSION_DONE_IRQ_O));
`default_nettype wire

// *** tb/analog_front_model.sv ***
// behavioural analog front end: sample-hold, tap ladder and comparator
// assumes a 4000 mV reference and tap codes straight from the sequencer
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
(
  // clock and analog input
  input wire logic clk_i,
  input wire logic [11:0] vin_mv_i,
  // sequencer side
  input wire logic sample_i,
  input wire logic comp_on_i,
  input wire logic [9:0] tap_i,
  output logic comp_high_o
);
  // ==========================================================
  // hold and compare
  logic [11:0] held_q;
  logic junk_q = 1'b0;
  always @(posedge clk_i)
  begin
    if (sample_i)
      held_q <= vin_mv_i;
    junk_q <= ~junk_q;
  end
  // threshold half a step under the tap gives rounding to nearest
  // a powered-down comparator answers nothing useful, so it toggles
  assign comp_high_o = comp_on_i ? (int'(held_q) * 2048 >= (int'(tap_i) * 2 - 1) * 4000) : junk_q;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// bench for the converter sequencer: registers, both start modes, timing
// assumes the analog front model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_sequencer_defs.vh"
module tb_top;
  localparam logic [31:0] MR = `ADDR_MODE_REG;
  localparam logic [31:0] CS = `ADDR_CHANNEL_SELECT;
  localparam logic [31:0] RR = `ADDR_RESULT_REG;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop = 1'b0;
  logic trig = 1'b0;
  logic [31:0] addr = 32'h0000_0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] mask = 8'h00;
  logic [11:0] vin [0:11];
  logic [15:0] got;
  wire [15:0] rdata;
  wire [3:0] chan;
  wire [9:0] tap;
  wire hi, smp, con, irq;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc;
  int e;
  int len;
  int lens [8] = '{288, 216, 168, 120, 96, 72, 60, 48};
  always #25 clk = ~clk;
  sar_adc_sequencer u_sar_adc_sequencer (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WR_I(wr), .WDATA_I(wdata),
    .BIT_MASK_I(mask), .RD_I(rd), .RDATA_O(rdata), .LOW_POWER_STOP_I(stop), .EXTERNAL_TRIGGER_IN_I(trig),
    .COMPARATOR_HIGH_I(hi), .CHANNEL_O(chan), .SAMPLE_O(smp), .TAP_CODE_O(tap), .COMPARATOR_ON_O(con),
    .CONVERSION_DONE_IRQ_O(irq));
  analog_front_model u_analog_front_model (.clk_i(clk), .vin_mv_i(vin[chan]), .sample_i(smp), .comp_on_i(con),
    .tap_i(tap), .comp_high_o(hi));
  // ==========================================================
  // tasks
  function automatic logic [15:0] code_of(input logic [11:0] mv);
    return 16'((int'(mv) * 2048 + 4000) / 8000);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    #2 wr = w;
    rd = ~w;
    addr = a;
    wdata = d;
    mask = m;
    @(posedge clk);
    #2 wr = 1'b0;
    rd = 1'b0;
    got = rdata;
  endtask
  // a wait that should see a pulse and does not ends the run
  task automatic expect_irq(input int bound, input logic want);
    cyc = -1;
    for (int i = 1; i <= bound && cyc < 0; i++)
    begin
      @(posedge clk);
      #1 if (irq === 1'b1) cyc = i;
    end
    check(16'(cyc >= 0), 16'(want));
    if (want && cyc < 0)
      give_verdict();
  endtask
  // ==========================================================
  // sequence
  initial
  begin
    e = $urandom(81);
    for (int i = 0; i < 12; i++)
      vin[i] = 12'($urandom_range(3990));
    vin[0] = 12'h000;
    vin[11] = 12'hF96;
    repeat (16) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    acc(0, CS, 8'h00, 8'h00);
    check(got, 16'h0000);
    acc(0, RR, 8'h00, 8'h00);
    check(got, 16'h0000);
    acc(0, 32'hFFFF_F3C6, 8'h00, 8'h00);
    check(got, 16'h0000);
    acc(1, CS, 8'h0B, 8'hFF);
    acc(1, CS, 8'h00, 8'h08);
    acc(0, CS, 8'h00, 8'h00);
    check(got, 16'h0003);
    acc(1, MR, 8'hB8, 8'hFF);
    for (int k = 0; k < 6; k++)
    begin
      e = (k == 0) ? 11 : (k == 1) ? 0 : $urandom_range(11);
      expect_irq(80, 1);
      repeat (5) @(posedge clk);
      acc(1, CS, 8'(e), 8'hFF);
      expect_irq(80, 1);
      acc(0, RR, 8'h00, 8'h00);
      check(got, code_of(vin[e]));
      expect_irq(80, 1);
    end
    repeat (10) @(posedge clk);
    acc(1, MR, 8'h38, 8'hFF);
    expect_irq(200, 0);
    for (int t = 0; t < 8; t++)
    begin
      acc(1, MR, {2'b10, 3'(t), 2'b00, 1'(t)}, 8'hFF);
      expect_irq(700, 1);
      expect_irq(700, 1);
      len = (lens[t] / 11) * 11 + ((t % 2) ? lens[t] / 2 : 0);
      check(16'(cyc >= len && cyc <= len + 3), 16'h0001);
    end
    acc(1, MR, 8'hB8, 8'hFF);
    @(posedge clk);
    #2 stop = 1'b1;
    expect_irq(200, 0);
    #1 stop = 1'b0;
    expect_irq(80, 1);
    // restart on a channel whose code differs from the stored one
    len = (code_of(vin[e]) == 16'h0000) ? 11 : 0;
    acc(1, CS, 8'(len), 8'hFF);
    repeat (44) @(posedge clk);
    // this read meets the commit cycle, so the old code comes first
    acc(0, RR, 8'h00, 8'h00);
    check(got, code_of(vin[e]));
    expect_irq(2, 1);
    acc(0, RR, 8'h00, 8'h00);
    check(got, code_of(vin[len]));
    acc(1, CS, 8'(e), 8'hFF);
    repeat (44) @(posedge clk);
    // a store on the commit cycle drops that result and its pulse
    acc(1, CS, 8'(len), 8'hFF);
    acc(0, RR, 8'h00, 8'h00);
    check(got, code_of(vin[len]));
    expect_irq(40, 0);
    for (int g = 0; g < 4; g++)
    begin
      acc(1, MR, 8'h38, 8'hFF);
      trig = (g == 1);
      acc(1, MR, 8'hF8 | 8'(g << 1), 8'hFF);
      expect_irq(150, 0);
      @(posedge clk);
      #2 trig = ~trig;
      repeat (10) @(posedge clk);
      // a second edge mid-conversion must be dropped, not queued
      #2 trig = ~trig;
      expect_irq(80, g != 0);
      if (g != 0)
        acc(0, RR, 8'h00, 8'h00);
      if (g != 0)
        check(got, code_of(vin[len]));
      // this quiet gap also spaces the next trigger edge well apart
      expect_irq(150, 0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
